// ==== verilog/clkcond_pkg.sv ====
// Constants, register map and types for the sample clock conditioner
package clkcond_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_DELAY_MODE = 10'h110;
    localparam logic [9:0] IDX_VERNIER = 10'h111;
    localparam logic [9:0] IDX_COARSE = 10'h112;
    localparam logic [9:0] IDX_MON_SETUP = 10'h11a;
    localparam logic [9:0] IDX_PRESENCE = 10'h11b;
    localparam logic [9:0] IDX_DUTY = 10'h11c;
    localparam logic [9:0] IDX_FSYNC1 = 10'h120;
    localparam logic [9:0] IDX_FSYNC_FLAGS = 10'h12e;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h130;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h131;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_DELAY_MODE = 3'h0;
    localparam logic [7:0] RST_VERNIER = 8'h00;
    localparam logic [7:0] RST_COARSE = 8'hc0;
    localparam logic [2:0] RST_MON_RSVD = 3'h0;
    localparam logic [1:0] RST_MON_THRESH = 2'h1;
    localparam logic RST_MON_EN = 1'b1;
    localparam logic [4:0] RST_DUTY_RSVD = 5'h01;
    localparam logic RST_DUTY_EN = 1'b0;
    localparam logic RST_DUTY_PWR = 1'b0;
    localparam logic RST_FLAG_HOLD = 1'b0;
    localparam logic [2:0] RST_IRQ = 3'h0;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_MON_RSVD = 5;
    localparam int POS_MON_THRESH = 3;
    localparam int POS_MON_EN = 2;
    localparam int POS_DUTY_RSVD = 3;
    localparam int POS_DUTY_EN = 1;
    localparam int POS_DUTY_PWR = 0;
    localparam int POS_PRESENT = 0;
    localparam int POS_FLAG_HOLD = 6;
    localparam int POS_FLAG_SETUP = 0;
    localparam int POS_FLAG_HOLDERR = 1;
    localparam int POS_IRQ_CLK = 0;
    localparam int POS_IRQ_SETUP = 1;
    localparam int POS_IRQ_HOLD = 2;
    // ------------------------------------------------------------
    // Delay modes, limits and step sizes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DLY_OFF = 3'b000,
        DLY_RSVD1 = 3'b001,
        DLY_FINE16 = 3'b010,
        DLY_FINE16_LJ = 3'b011,
        DLY_FINE_FULL = 3'b100,
        DLY_FINE_ALT = 3'b101,
        DLY_FINE_VERN = 3'b110,
        DLY_RSVD7 = 3'b111
    } delay_mode_t;
    localparam logic [7:0] COARSE_MAX = 8'hc0;
    localparam logic [7:0] COARSE_REDUCED_MAX = 8'h10;
    localparam logic [7:0] VERNIER_MAX = 8'h80;
    localparam logic [18:0] COARSE_STEP_FS = 19'd1725;
    localparam logic [18:0] VERNIER_STEP_FS = 19'd250;
    // ------------------------------------------------------------
    // Clock detector thresholds and timing
    // ------------------------------------------------------------
    localparam logic [1:0] THRESH_200 = 2'b01;
    localparam logic [1:0] THRESH_150 = 2'b11;
    localparam int CLK_PERIOD_NS = 40;
    localparam int GATE_NS = 10240;
    localparam int GATE_CYC = GATE_NS / CLK_PERIOD_NS;
    localparam int PRESCALE = 64;
    localparam int MHZ_HI = 200;
    localparam int MHZ_LO = 150;
    localparam int EDGES_HI = 2 * MHZ_HI * GATE_NS / 1000 / PRESCALE;
    localparam int EDGES_LO = 2 * MHZ_LO * GATE_NS / 1000 / PRESCALE;
endpackage

// ==== verilog/clkdet_if.sv ====
// Link between the register block and the clock presence meter
`timescale 1ns/1ps
interface clkdet_if;
    logic enable;
    logic [1:0] thresh;
    logic present;
    logic window_done;
    modport ctrl (output enable, output thresh, input present, input window_done);
    modport meter (input enable, input thresh, output present, output window_done);
endinterface

// ==== verilog/clock_presence_meter.sv ====
// Gated transition counter that decides whether the input clock is present
`timescale 1ns/1ps
module clock_presence_meter
    import clkcond_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Prescaled sample clock pin
    input wire logic div_clk_i,
    // Control side
    clkdet_if.meter mon
);
    logic [2:0] sync;
    logic level;
    logic [7:0] gate_cnt;
    logic [7:0] edge_cnt;
    logic [7:0] need;
    logic present;
    logic done;

    assign mon.present = present;
    assign mon.window_done = done;

    // ------------------------------------------------------------
    // Pin synchroniser; a change counts once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync <= 3'h0;
            level <= 1'b0;
        end
        else
        begin
            sync <= {sync[1:0], div_clk_i};
            if (sync[1] == sync[2])
            begin
                level <= sync[2];
            end
        end
    end

    // Threshold in transitions per gate; unlisted codes take the higher one
    always_comb
    begin
        if (mon.thresh == THRESH_150)
        begin
            need = 8'(EDGES_LO);
        end
        else
        begin
            need = 8'(EDGES_HI);
        end
    end

    // ------------------------------------------------------------
    // Gate window; a disabled detector reports no clock
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gate_cnt <= 8'h00;
            edge_cnt <= 8'h00;
            present <= 1'b0;
            done <= 1'b0;
        end
        else if (!mon.enable)
        begin
            gate_cnt <= 8'h00;
            edge_cnt <= 8'h00;
            present <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= (gate_cnt == 8'(GATE_CYC - 1));
            if (gate_cnt == 8'(GATE_CYC - 1))
            begin
                gate_cnt <= 8'h00;
                edge_cnt <= 8'h00;
                present <= (edge_cnt >= need);
            end
            else
            begin
                gate_cnt <= gate_cnt + 8'h01;
                // Saturate so a runaway input cannot wrap below the threshold
                if ((sync[1] == sync[2]) && (sync[2] != level) && (edge_cnt != 8'hff))
                begin
                    edge_cnt <= edge_cnt + 8'h01;
                end
            end
        end
    end
endmodule

// ==== verilog/sample_clock_conditioner.sv ====
// Sample clock delay, presence monitor, duty stabilizer and frame sync flag control
//
// Contract
// - Vernier field counts 0.25 ps steps, zero none
// - Vernier codes up to 0x80 map linearly
// - Coarse skew field counts 1.725 ps steps
// - Coarse skew up to 0xc0, resets to 0xc0
// - Presence status bit 0, read only, resets 0
// - Flag hold bit keeps sync error flags cleared
// - Full modes take 192 steps, reduced take 16
// - Vernier acts only in delay mode 110
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module sample_clock_conditioner
    import clkcond_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Pins from outside the clock domain
    input wire logic SAMPLE_CLK_DIV_I,
    input wire logic SYSREF_SETUP_ERR_I,
    input wire logic SYSREF_HOLD_ERR_I,
    // Delay line control
    output logic [7:0] COARSE_STEPS_O,
    output logic [7:0] VERNIER_STEPS_O,
    output logic [18:0] TOTAL_DELAY_FS_O,
    // Duty cycle stabilizer control
    output logic DUTY_STAB_POWER_O,
    output logic DUTY_STAB_ENABLE_O,
    // Status and interrupt
    output logic CLOCK_PRESENT_O,
    output logic SYSREF_SETUP_FLAG_O,
    output logic SYSREF_HOLD_FLAG_O,
    output logic IRQ_O
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    clkdet_if mon ();

    logic [2:0] mode;
    logic [7:0] vernier;
    logic [7:0] coarse;
    logic [2:0] mon_rsvd;
    logic [1:0] mon_thresh;
    logic mon_en;
    logic [4:0] duty_rsvd;
    logic duty_en;
    logic duty_pwr;
    logic flag_hold;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [1:0] err_flags;
    logic present_q;

    logic [9:0] idx;
    logic wr_en;
    logic [7:0] wbyte;
    logic [31:0] next_rdata;
    logic next_slverr;

    logic [2:0] err_sync [2];
    logic [1:0] err_level;
    logic [1:0] err_rise;
    logic [2:0] events;

    logic [7:0] next_coarse;
    logic [7:0] next_vernier;

    // ------------------------------------------------------------
    // Clock presence meter
    // ------------------------------------------------------------
    assign mon.enable = mon_en;
    assign mon.thresh = mon_thresh;

    clock_presence_meter meter_u (
        .clk_i (CLK_I),
        .rst_n_i (RST_N_I),
        .div_clk_i (SAMPLE_CLK_DIV_I),
        .mon (mon.meter)
    );

    // ------------------------------------------------------------
    // APB decode; no wait state, read data leave a flip-flop loaded in the setup cycle
    // ------------------------------------------------------------
    assign idx = PADDR_I[11:2];
    assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0];
    assign wbyte = PWDATA_I[7:0];

    // Read multiplexer, sampled during the setup cycle
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (idx)
            IDX_DELAY_MODE: next_rdata[2:0] = mode;
            IDX_VERNIER: next_rdata[7:0] = vernier;
            IDX_COARSE: next_rdata[7:0] = coarse;
            IDX_MON_SETUP:
            begin
                next_rdata[POS_MON_RSVD +: 3] = mon_rsvd;
                next_rdata[POS_MON_THRESH +: 2] = mon_thresh;
                next_rdata[POS_MON_EN] = mon_en;
            end
            IDX_PRESENCE: next_rdata[POS_PRESENT] = present_q;
            IDX_DUTY:
            begin
                next_rdata[POS_DUTY_RSVD +: 5] = duty_rsvd;
                next_rdata[POS_DUTY_EN] = duty_en;
                next_rdata[POS_DUTY_PWR] = duty_pwr;
            end
            IDX_FSYNC1: next_rdata[POS_FLAG_HOLD] = flag_hold;
            IDX_FSYNC_FLAGS: next_rdata[1:0] = err_flags;
            IDX_IRQ_STATUS: next_rdata[2:0] = irq_status;
            IDX_IRQ_MASK: next_rdata[2:0] = irq_mask;
            default: next_slverr = 1'b1;
        endcase
    end

    // Bus answer flops
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            PREADY_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            if (PSEL_I && !PENABLE_I)
            begin
                PRDATA_O <= PWRITE_I ? 32'h0000_0000 : next_rdata;
                PSLVERR_O <= next_slverr;
            end
            else
            begin
                PSLVERR_O <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers written by software
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            mode <= RST_DELAY_MODE;
            vernier <= RST_VERNIER;
            coarse <= RST_COARSE;
            mon_rsvd <= RST_MON_RSVD;
            mon_thresh <= RST_MON_THRESH;
            mon_en <= RST_MON_EN;
            duty_rsvd <= RST_DUTY_RSVD;
            duty_en <= RST_DUTY_EN;
            duty_pwr <= RST_DUTY_PWR;
            flag_hold <= RST_FLAG_HOLD;
            irq_mask <= RST_IRQ;
        end
        else if (wr_en)
        begin
            case (idx)
                IDX_DELAY_MODE: mode <= wbyte[2:0];
                IDX_VERNIER: vernier <= wbyte;
                IDX_COARSE: coarse <= wbyte;
                IDX_MON_SETUP:
                begin
                    mon_rsvd <= wbyte[POS_MON_RSVD +: 3];
                    mon_thresh <= wbyte[POS_MON_THRESH +: 2];
                    mon_en <= wbyte[POS_MON_EN];
                end
                IDX_DUTY:
                begin
                    duty_rsvd <= wbyte[POS_DUTY_RSVD +: 5];
                    duty_en <= wbyte[POS_DUTY_EN];
                    duty_pwr <= wbyte[POS_DUTY_PWR];
                end
                IDX_FSYNC1: flag_hold <= wbyte[POS_FLAG_HOLD];
                IDX_IRQ_MASK: irq_mask <= wbyte[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Delay steps actually applied, by mode
    // ------------------------------------------------------------
    // Out-of-range codes saturate rather than wrap, so a bad write never
    // jumps the clock edge to the far end of the line.
    always_comb
    begin
        next_coarse = 8'h00;
        next_vernier = 8'h00;
        case (delay_mode_t'(mode))
            DLY_FINE16, DLY_FINE16_LJ:
            begin
                // Reduced range modes take only steps 0 to 16
                next_coarse = (coarse > COARSE_REDUCED_MAX) ? COARSE_REDUCED_MAX : coarse;
            end
            DLY_FINE_FULL, DLY_FINE_ALT:
            begin
                next_coarse = (coarse > COARSE_MAX) ? COARSE_MAX : coarse;
            end
            DLY_FINE_VERN:
            begin
                next_coarse = (coarse > COARSE_MAX) ? COARSE_MAX : coarse;
                next_vernier = (vernier > VERNIER_MAX) ? VERNIER_MAX : vernier;
            end
            default:
            begin
                // No delay, and reserved codes treated as no delay
                next_coarse = 8'h00;
                next_vernier = 8'h00;
            end
        endcase
    end

    // Registered delay outputs with total delay in femtoseconds
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            COARSE_STEPS_O <= 8'h00;
            VERNIER_STEPS_O <= 8'h00;
            TOTAL_DELAY_FS_O <= 19'h00000;
        end
        else
        begin
            COARSE_STEPS_O <= next_coarse;
            VERNIER_STEPS_O <= next_vernier;
            // Linear in each count: 1.725 ps and 0.25 ps per step
            TOTAL_DELAY_FS_O <= 19'({11'h000, next_coarse} * COARSE_STEP_FS)
                + 19'({11'h000, next_vernier} * VERNIER_STEP_FS);
        end
    end

    // ------------------------------------------------------------
    // Duty cycle stabilizer
    // ------------------------------------------------------------
    // Power and enable are passed through as written; enable without power
    // is left to software ordering, the stabilizer stays bypassed while clear.
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            DUTY_STAB_POWER_O <= 1'b0;
            DUTY_STAB_ENABLE_O <= 1'b0;
        end
        else
        begin
            DUTY_STAB_POWER_O <= duty_pwr;
            DUTY_STAB_ENABLE_O <= duty_en;
        end
    end

    // ------------------------------------------------------------
    // Frame sync error pins: three-stage synchronisers
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_err
            always_ff @(posedge CLK_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                begin
                    err_sync[i] <= 3'h0;
                    err_level[i] <= 1'b0;
                end
                else
                begin
                    err_sync[i] <= {err_sync[i][1:0],
                        (i == 0) ? SYSREF_SETUP_ERR_I : SYSREF_HOLD_ERR_I};
                    if (err_sync[i][1] == err_sync[i][2])
                    begin
                        err_level[i] <= err_sync[i][2];
                    end
                end
            end
            assign err_rise[i] = (err_sync[i][1] == err_sync[i][2])
                && err_sync[i][2] && !err_level[i];
        end
    endgenerate

    // Sticky error flags; the hold bit clears them and blocks new sets
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            err_flags <= 2'h0;
        end
        else if (flag_hold)
        begin
            err_flags <= 2'h0;
        end
        else
        begin
            err_flags <= err_flags | err_rise;
        end
    end

    // ------------------------------------------------------------
    // Events, sticky status and interrupt
    // ------------------------------------------------------------
    assign events[POS_IRQ_CLK] = (mon.present != present_q);
    assign events[POS_IRQ_SETUP] = err_rise[POS_FLAG_SETUP] && !flag_hold;
    assign events[POS_IRQ_HOLD] = err_rise[POS_FLAG_HOLDERR] && !flag_hold;

    // Write one to clear; a set in the same cycle wins
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            irq_status <= RST_IRQ;
        end
        else
        begin
            if (wr_en && (idx == IDX_IRQ_STATUS))
            begin
                irq_status <= (irq_status & ~wbyte[2:0]) | events;
            end
            else
            begin
                irq_status <= irq_status | events;
            end
        end
    end

    // Status outputs and interrupt level
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            present_q <= 1'b0;
            CLOCK_PRESENT_O <= 1'b0;
            SYSREF_SETUP_FLAG_O <= 1'b0;
            SYSREF_HOLD_FLAG_O <= 1'b0;
            IRQ_O <= 1'b0;
        end
        else
        begin
            present_q <= mon.present;
            CLOCK_PRESENT_O <= mon.present;
            SYSREF_SETUP_FLAG_O <= err_flags[POS_FLAG_SETUP];
            SYSREF_HOLD_FLAG_O <= err_flags[POS_FLAG_HOLDERR];
            IRQ_O <= |(irq_status & irq_mask);
        end
    end
endmodule

// ==== tb/sample_clock_conditioner_chk.sv ====
// Port-level assertions for the sample clock conditioner
`timescale 1ns/1ps
module sample_clock_conditioner_chk
    import clkcond_pkg::*;
(
    // Clock, reset and bus
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // Delay line and sync flags
    input wire logic [7:0] COARSE_STEPS_O,
    input wire logic [7:0] VERNIER_STEPS_O,
    input wire logic [18:0] TOTAL_DELAY_FS_O,
    input wire logic SYSREF_SETUP_ERR_I,
    input wire logic SYSREF_HOLD_ERR_I,
    input wire logic SYSREF_SETUP_FLAG_O,
    input wire logic SYSREF_HOLD_FLAG_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    // Bus steps: setup then a single wait-free access
    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_access;
        PSEL_I && PENABLE_I && PREADY_O;
    endsequence
    property p_ready;
        s_setup |=> s_access;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_ready_once;
        s_access |=> !PREADY_O;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready held too long");
    property p_err_ready;
        PSLVERR_O |-> PREADY_O;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    // Applied step counts never pass their ceilings
    property p_coarse_max;
        COARSE_STEPS_O <= COARSE_MAX;
    endproperty
    a_coarse_max: assert property (p_coarse_max) else $error("coarse over max");
    property p_vern_max;
        VERNIER_STEPS_O <= VERNIER_MAX;
    endproperty
    a_vern_max: assert property (p_vern_max) else $error("vernier over max");
    // Total is linear in both counts; zero counts add nothing
    property p_total;
        TOTAL_DELAY_FS_O == 19'(COARSE_STEPS_O) * 19'd1725 + 19'(VERNIER_STEPS_O) * 19'd250;
    endproperty
    a_total: assert property (p_total) else $error("total delay wrong");
    // A flag only rises after its pin has been high through the synchronizer
    property p_setup_flag;
        $rose(SYSREF_SETUP_FLAG_O) |-> $past(SYSREF_SETUP_ERR_I, 3);
    endproperty
    a_setup_flag: assert property (p_setup_flag) else $error("setup flag uncaused");
    property p_hold_flag;
        $rose(SYSREF_HOLD_FLAG_O) |-> $past(SYSREF_HOLD_ERR_I, 3);
    endproperty
    a_hold_flag: assert property (p_hold_flag) else $error("hold flag uncaused");
endmodule
bind sample_clock_conditioner sample_clock_conditioner_chk sample_clock_conditioner_chk_inst (
    .CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PREADY_O, .PSLVERR_O, .COARSE_STEPS_O,
    .VERNIER_STEPS_O, .TOTAL_DELAY_FS_O, .SYSREF_SETUP_ERR_I, .SYSREF_HOLD_ERR_I,
    .SYSREF_SETUP_FLAG_O, .SYSREF_HOLD_FLAG_O);

// ==== tb/sample_clock_source.sv ====
// Far-side model: prescaled sample clock and sync error pins
`timescale 1ns/1ps
module sample_clock_source
(
    // Control from the bench
    input wire logic run_i,
    input wire logic slow_i,
    input wire logic [1:0] err_i,
    // Pins toward the device
    output logic div_clk_o,
    output logic setup_err_o,
    output logic hold_err_o
);
    // Stands still when stopped, so a dead clock shows no edges at all
    initial div_clk_o = 1'b0;
    always #(slow_i ? 180 : 80) if (run_i) div_clk_o = ~div_clk_o;
    // Error pins are levels; a rising level is one event
    assign setup_err_o = err_i[0];
    assign hold_err_o = err_i[1];
endmodule

// ==== tb/sample_clock_conditioner_tb_top.sv ====
// Self-checking bench for the sample clock conditioner
`timescale 1ns/1ps
module sample_clock_conditioner_tb_top import clkcond_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h1;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic [1:0] err_req = 2'h0;
    logic [31:0] prdata;
    logic pready, pslverr, div_clk, serr, herr, dpwr, den, present, sflag, hflag, irq;
    logic [7:0] coarse, vern;
    logic [18:0] total;
    logic [31:0] rd;
    logic er;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    // Clock of 40 ns
    always #20 clk = ~clk;
    sample_clock_source sample_clock_source_inst (.run_i(run), .slow_i(slow), .err_i(err_req),
        .div_clk_o(div_clk), .setup_err_o(serr), .hold_err_o(herr));
    sample_clock_conditioner sample_clock_conditioner_inst (.CLK_I(clk), .RST_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .SAMPLE_CLK_DIV_I(div_clk), .SYSREF_SETUP_ERR_I(serr),
        .SYSREF_HOLD_ERR_I(herr), .COARSE_STEPS_O(coarse), .VERNIER_STEPS_O(vern),
        .TOTAL_DELAY_FS_O(total), .DUTY_STAB_POWER_O(dpwr), .DUTY_STAB_ENABLE_O(den),
        .CLOCK_PRESENT_O(present), .SYSREF_SETUP_FLAG_O(sflag),
        .SYSREF_HOLD_FLAG_O(hflag), .IRQ_O(irq));
    task end_sim;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard: the full run needs about 3200 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            fails++;
            end_sim();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer; request held until ready is seen at an edge
    task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        chk(32'(n), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task rdc(input logic [9:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(rd, 32'(e));
    endtask
    task t_reset;
        logic [9:0] ix [9];
        logic [7:0] v [9];
        ix = '{IDX_DELAY_MODE, IDX_VERNIER, IDX_COARSE, IDX_MON_SETUP, IDX_PRESENCE,
            IDX_DUTY, IDX_FSYNC1, IDX_IRQ_STATUS, IDX_IRQ_MASK};
        v = '{8'h00, 8'h00, 8'hc0, 8'h0c, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
        foreach (ix[i]) rdc(ix[i], v[i]);
        chk(32'(coarse), 32'h0);
        apb(1'b0, 10'h3ff, 8'h00);
        chk(32'(er), 32'h1);
        wr(IDX_PRESENCE, 8'hff);
        rdc(IDX_PRESENCE, 8'h00);
        wr(IDX_MON_SETUP, 8'h1c);
        rdc(IDX_MON_SETUP, 8'h1c);
        wr(IDX_MON_SETUP, 8'h0c);
    endtask
    task t_delay;
        logic [7:0] ec [8];
        logic [7:0] ev [8];
        ec = '{8'h00, 8'h00, 8'h10, 8'h10, 8'hc0, 8'hc0, 8'hc0, 8'h00};
        ev = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
        wr(IDX_COARSE, 8'hff);
        wr(IDX_VERNIER, 8'hff);
        for (int m = 0; m < 8; m++)
        begin
            wr(IDX_DELAY_MODE, m[7:0]);
            wt(3);
            chk(32'(coarse), 32'(ec[m]));
            chk(32'(vern), 32'(ev[m]));
        end
        wr(IDX_DELAY_MODE, 8'h06);
        wr(IDX_COARSE, 8'h08);
        wr(IDX_VERNIER, 8'h08);
        wt(3);
        chk(32'(total), 32'd15800);
        wr(IDX_VERNIER, 8'h00);
        wr(IDX_COARSE, 8'hc0);
        wt(3);
        chk(32'(total), 32'd331200);
    endtask
    task t_presence;
        run <= 1'b1;
        wt(600);
        chk(32'(present), 32'h1);
        rdc(IDX_PRESENCE, 8'h01);
        chk(32'(irq), 32'h0);
        wr(IDX_IRQ_MASK, 8'h01);
        wt(3);
        chk(32'(irq), 32'h1);
        wr(IDX_IRQ_STATUS, 8'h01);
        wt(3);
        chk(32'(irq), 32'h0);
        wr(IDX_MON_SETUP, 8'h08);
        wt(4);
        chk(32'(present), 32'h0);
        chk(32'(irq), 32'h1);
        wr(IDX_MON_SETUP, 8'h0c);
        wt(600);
        chk(32'(present), 32'h1);
        slow <= 1'b1;
        wt(600);
        rdc(IDX_PRESENCE, 8'h00);
        wr(IDX_MON_SETUP, 8'h1c);
        wt(600);
        chk(32'(present), 32'h1);
        wr(IDX_MON_SETUP, 8'h0c);
        run <= 1'b0;
        wt(600);
        wr(IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_MASK, 8'h00);
    endtask
    task t_flags;
        err_req <= 2'b01;
        wt(10);
        chk(32'(sflag), 32'h1);
        wr(IDX_FSYNC1, 8'h40);
        wt(3);
        chk(32'(sflag), 32'h0);
        err_req <= 2'b10;
        wt(10);
        chk(32'(hflag), 32'h0);
        err_req <= 2'b00;
        wr(IDX_FSYNC1, 8'h00);
        err_req <= 2'b10;
        wt(10);
        chk(32'(hflag), 32'h1);
        rdc(IDX_FSYNC_FLAGS, 8'h02);
        err_req <= 2'b00;
        rdc(IDX_IRQ_STATUS, 8'h06);
        wr(IDX_IRQ_STATUS, 8'h06);
        rdc(IDX_IRQ_STATUS, 8'h00);
    endtask
    // Stabilizer is powered before it is enabled
    task t_duty;
        wr(IDX_DUTY, 8'h09);
        wt(2);
        chk(32'({dpwr, den}), 32'h2);
        wr(IDX_DUTY, 8'h0b);
        wt(2);
        chk(32'({dpwr, den}), 32'h3);
        rdc(IDX_DUTY, 8'h0b);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_delay();
        t_presence();
        t_flags();
        t_duty();
        end_sim();
    end
endmodule
